// file: cqm_card.sv
// Card end: command decoder, enhancement bytes, maintenance and task queue control.
// Assumes the host makes linkClk and changes cmdLine on its falling edges.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
module cqm_card #(
  parameter longint MAINT_CYCLES = cqm_pkg::MAINT_LIMIT_CYC,
  parameter int     QDEPTH       = 5'd16
) (
  // System
  input  wire logic       clk,
  input  wire logic       rst,
  // Link
  cqm_link_if.card        link,
  // Internal maintenance engine, operation done and queue mode outputs
  input  wire logic [1:0] maintUrgency,
  input  wire logic       maintWorkDone,
  input  wire logic       opDone,
  output logic            maintActive,
  output logic            queueOn,
  output logic            queueSeq,
  output logic            powerOffSafe
);
  logic [2:0] clkSync_reg, cmdSync_reg;
  logic       clkLvl_reg, cmdLvl_reg, edgeSeen;
  logic       rxBusy_reg, txBusy_reg, txArm_reg, pend44_reg, illegal_reg, seqErr_reg;
  logic [4:0] rxCnt_reg, txCnt_reg, seqAssign_reg, seqExec_reg;
  logic [cqm_pkg::CMD_W-1:0] rxSh_reg;
  logic [cqm_pkg::RSP_W:0]   txSh_reg;
  logic       decode_reg;
  logic [7:0] evtEn_reg, maintEn_reg, urgency_reg;
  logic       qEn_reg, qSeq_reg, cache_reg, poff_reg, hostRun_reg, cardRun_reg;
  logic [63:0] runCnt_reg;
  cqm_pkg::cqm_qstate_t qst_reg;
  localparam int ADW = cqm_pkg::ADDR_W;
  logic [5:0] idx;
  logic [ADW-1:0] addr;
  logic [4:0] tid;
  logic       legal, busIdle;
  logic [7:0] rdData;

  assign idx  = rxSh_reg[cqm_pkg::CMD_W-1 -: cqm_pkg::IDX_W];
  assign addr = rxSh_reg[cqm_pkg::ADDR_LSB +: ADW];
  assign tid  = rxSh_reg[4:0];
  assign busIdle = !rxBusy_reg && !txBusy_reg && !txArm_reg && !decode_reg;

  // Three-stage sampling; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      clkSync_reg <= 3'h0;
      cmdSync_reg <= 3'h7;
      clkLvl_reg  <= 1'b0;
      cmdLvl_reg  <= 1'b1;
    end else begin
      clkSync_reg <= {clkSync_reg[1:0], link.linkClk};
      cmdSync_reg <= {cmdSync_reg[1:0], link.cmdLine};
      if (clkSync_reg[1] == clkSync_reg[2]) clkLvl_reg <= clkSync_reg[2];
      if (cmdSync_reg[1] == cmdSync_reg[2]) cmdLvl_reg <= cmdSync_reg[2];
    end
  end
  assign edgeSeen = (clkSync_reg[1] == clkSync_reg[2]) && clkSync_reg[2] && !clkLvl_reg;

  // Legality per queue mode
  function automatic logic cmdLegal(input logic [5:0] c, input logic qOn);
    logic qCmd;
    qCmd = (c >= cqm_pkg::C_QMGMT) && (c <= cqm_pkg::C_EXWR);
    if (!qOn) return !qCmd;
    case (c)
      cqm_pkg::C_RESET, cqm_pkg::C_STOP, cqm_pkg::C_STATUS, cqm_pkg::C_UADDR,
      cqm_pkg::C_ESTART, cqm_pkg::C_EEND, cqm_pkg::C_ERASE, cqm_pkg::C_XRD,
      cqm_pkg::C_XWR, cqm_pkg::C_XMRD, cqm_pkg::C_XMWR, cqm_pkg::C_SWITCH,
      cqm_pkg::C_TUNE: return 1'b1;
      default: return qCmd;
    endcase
  endfunction : cmdLegal

  // Sequence checks on top of the mode table
  always_comb begin
    legal = cmdLegal(idx, qEn_reg);
    if (qEn_reg && idx == cqm_pkg::C_TASKA && (tid >= QDEPTH[4:0] || (qSeq_reg && tid != seqAssign_reg)))
      legal = 1'b0;
    if (qEn_reg && idx == cqm_pkg::C_TASKB && !pend44_reg) legal = 1'b0;
    if (qEn_reg && qSeq_reg && (idx == cqm_pkg::C_EXRD || idx == cqm_pkg::C_EXWR)
        && (tid != seqExec_reg || tid >= seqAssign_reg))
      legal = 1'b0;
  end

  always_comb begin
    case (addr)
      cqm_pkg::EB_EVT_SUP:   rdData = 8'h01;
      cqm_pkg::EB_MAINT_SUP: rdData = 8'h03;
      cqm_pkg::EB_URGENCY:   rdData = urgency_reg;
      cqm_pkg::EB_CACHE_SUP: rdData = 8'h01;
      cqm_pkg::EB_QUEUE:     rdData = {3'h0, QDEPTH[4:0] - 5'h01};
      cqm_pkg::EB_EVT_EN:    rdData = evtEn_reg;
      cqm_pkg::EB_MAINT_EN:  rdData = maintEn_reg;
      cqm_pkg::EB_POFF:      rdData = {7'h00, poff_reg};
      cqm_pkg::EB_CACHE_CTL: rdData = {7'h00, cache_reg};
      cqm_pkg::EB_QUEUE_CTL: rdData = {6'h00, qSeq_reg, qEn_reg};
      default:               rdData = 8'h00;
    endcase
  end

  // Receive frames and send answers
  always_ff @(posedge clk) begin
    if (rst) begin
      rxBusy_reg <= 1'b0;
      rxCnt_reg  <= 5'h00;
      rxSh_reg   <= '0;
      decode_reg <= 1'b0;
      txBusy_reg <= 1'b0;
      txArm_reg  <= 1'b0;
      txCnt_reg  <= 5'h00;
      txSh_reg   <= '1;
    end else begin
      decode_reg <= 1'b0;
      if (edgeSeen && !rxBusy_reg && !txBusy_reg && !txArm_reg && !cmdLvl_reg) begin
        rxBusy_reg <= 1'b1;
        rxCnt_reg  <= 5'h00;
      end else if (edgeSeen && rxBusy_reg) begin
        rxSh_reg  <= {rxSh_reg[cqm_pkg::CMD_W-2:0], cmdLvl_reg};
        rxCnt_reg <= rxCnt_reg + 5'h01;
        if (rxCnt_reg == 5'(cqm_pkg::CMD_W - 1)) begin
          rxBusy_reg <= 1'b0;
          decode_reg <= 1'b1;
        end
      end
      if (decode_reg && legal) begin
        txArm_reg  <= 1'b1;
        txCnt_reg  <= 5'h00;
        txSh_reg   <= {1'b0, stateCode(), illegal_reg, seqErr_reg,
                       (idx == cqm_pkg::C_STATUS) ? {QDEPTH[4:0] - 5'h01, 3'h7} : rdData};
      end else if (edgeSeen && txArm_reg) begin
        // Start bit waits for a link edge so it stands a full link period
        txArm_reg  <= 1'b0;
        txBusy_reg <= 1'b1;
      end else if (edgeSeen && txBusy_reg) begin
        txSh_reg  <= {txSh_reg[cqm_pkg::RSP_W-1:0], 1'b1};
        txCnt_reg <= txCnt_reg + 5'h01;
        if (txCnt_reg == 5'(cqm_pkg::RSP_W)) txBusy_reg <= 1'b0;
      end
    end
  end

  function automatic logic [3:0] stateCode();
    if (!qEn_reg) return cqm_pkg::ST_TRAN;
    case (qst_reg)
      cqm_pkg::Q_RDT: return cqm_pkg::ST_RDT;
      cqm_pkg::Q_WDT: return cqm_pkg::ST_WDT;
      cqm_pkg::Q_BSY: return cqm_pkg::ST_BSY;
      default:        return cqm_pkg::ST_TRAN;
    endcase
  endfunction : stateCode

  // Illegal flag shows in the next answer; a new illegal command wins over the clear
  always_ff @(posedge clk) begin
    if (rst) illegal_reg <= 1'b0;
    else if (decode_reg) illegal_reg <= !legal;
  end

  // Enhancement byte writes and queue bookkeeping
  always_ff @(posedge clk) begin
    if (rst) begin
      evtEn_reg <= 8'h00;
      maintEn_reg <= 8'h00;
      cache_reg <= 1'b0;
      poff_reg <= 1'b0;
      qEn_reg <= 1'b0;
      qSeq_reg <= 1'b0;
      pend44_reg <= 1'b0;
      seqAssign_reg <= 5'h00;
      seqExec_reg <= 5'h00;
      seqErr_reg <= 1'b0;
      qst_reg <= cqm_pkg::Q_TRAN;
    end else begin
      if (opDone) qst_reg <= cqm_pkg::Q_TRAN;
      if (decode_reg) begin
        pend44_reg <= legal && qEn_reg && idx == cqm_pkg::C_TASKA;
        if (!legal && qEn_reg && qSeq_reg) seqErr_reg <= 1'b1;
        if (legal) begin
          case (idx)
            cqm_pkg::C_RESET: begin
              qEn_reg <= 1'b0;
              seqAssign_reg <= 5'h00;
              seqExec_reg <= 5'h00;
              qst_reg <= cqm_pkg::Q_TRAN;
            end
            cqm_pkg::C_XWR: begin
              qst_reg <= qEn_reg ? cqm_pkg::Q_WDT : cqm_pkg::Q_TRAN;
              case (addr)
                cqm_pkg::EB_EVT_EN:    evtEn_reg <= rxSh_reg[7:0];
                cqm_pkg::EB_MAINT_EN:  maintEn_reg <= rxSh_reg[7:0];
                cqm_pkg::EB_POFF:      poff_reg <= rxSh_reg[0];
                cqm_pkg::EB_CACHE_CTL: cache_reg <= rxSh_reg[0];
                cqm_pkg::EB_QUEUE_CTL: begin
                  qEn_reg  <= rxSh_reg[cqm_pkg::QC_EN_BIT];
                  qSeq_reg <= rxSh_reg[cqm_pkg::QC_SEQ_BIT];
                  seqAssign_reg <= 5'h00;
                  seqExec_reg <= 5'h00;
                  if (!rxSh_reg[cqm_pkg::QC_EN_BIT]) qst_reg <= cqm_pkg::Q_TRAN;
                end
                default: ;
              endcase
            end
            cqm_pkg::C_QMGMT: begin // Any abort empties the sequential tracker
              seqAssign_reg <= 5'h00;
              seqExec_reg <= 5'h00;
              seqErr_reg <= 1'b0;
              qst_reg <= cqm_pkg::Q_BSY;
            end
            cqm_pkg::C_TASKB: if (qSeq_reg) seqAssign_reg <= seqAssign_reg + 5'h01;
            cqm_pkg::C_EXRD, cqm_pkg::C_EXWR: begin // Priority bits are not looked at
              if (qSeq_reg) seqExec_reg <= seqExec_reg + 5'h01;
              qst_reg <= (idx == cqm_pkg::C_EXRD) ? cqm_pkg::Q_RDT : cqm_pkg::Q_WDT;
            end
            cqm_pkg::C_XRD, cqm_pkg::C_XMRD, cqm_pkg::C_TUNE:
              if (qEn_reg) qst_reg <= cqm_pkg::Q_RDT;
            cqm_pkg::C_XMWR: if (qEn_reg) qst_reg <= cqm_pkg::Q_WDT;
            cqm_pkg::C_ERASE: if (qEn_reg) qst_reg <= cqm_pkg::Q_BSY;
            cqm_pkg::C_STOP:
              qst_reg <= (qst_reg == cqm_pkg::Q_WDT) ? cqm_pkg::Q_BSY : cqm_pkg::Q_TRAN;
            default: ;
          endcase
        end
      end
    end
  end

  // Maintenance: card-initiated on idle bus, host-initiated for a bounded grant
  always_ff @(posedge clk) begin
    if (rst) begin
      urgency_reg <= 8'h00;
      cardRun_reg <= 1'b0;
      hostRun_reg <= 1'b0;
      runCnt_reg <= 64'h0000_0000_0000_0000;
      maintActive <= 1'b0;
      powerOffSafe <= 1'b0;
    end else begin
      if (maintUrgency != 2'h0) urgency_reg <= {6'h00, maintUrgency};
      else if (maintWorkDone) urgency_reg <= 8'h00;
      cardRun_reg <= maintEn_reg[cqm_pkg::ME_CARD_BIT] && maintEn_reg[cqm_pkg::ME_SUST_BIT]
                     && busIdle && !edgeSeen && !poff_reg && maintUrgency != 2'h0;
      if (decode_reg && legal && idx == cqm_pkg::C_XWR && addr == cqm_pkg::EB_MAINT_EN
          && rxSh_reg[cqm_pkg::ME_HOST_BIT] && urgency_reg != 8'h00) begin
        hostRun_reg <= 1'b1;
        runCnt_reg <= 64'(MAINT_CYCLES);
      end else if (decode_reg && legal && idx == cqm_pkg::C_XWR && addr == cqm_pkg::EB_POFF && rxSh_reg[0]) begin
        runCnt_reg <= 64'(MAINT_CYCLES);
      end else if (runCnt_reg != 64'h0000_0000_0000_0000) begin
        runCnt_reg <= runCnt_reg - 64'h0000_0000_0000_0001;
      end
      if (maintWorkDone || (hostRun_reg && runCnt_reg == 64'h0000_0000_0000_0001)) hostRun_reg <= 1'b0;
      // After power-off notice the grace count ends any activity
      if (poff_reg && runCnt_reg == 64'h0000_0000_0000_0000) hostRun_reg <= 1'b0;
      maintActive <= (cardRun_reg || hostRun_reg) && !(poff_reg && runCnt_reg == 64'h0000_0000_0000_0000);
      powerOffSafe <= poff_reg && (runCnt_reg == 64'h0000_0000_0000_0000 || !(cardRun_reg || hostRun_reg));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      link.rspLine <= 1'b1;
      link.eventLine <= 1'b0;
      queueOn <= 1'b0;
      queueSeq <= 1'b0;
    end else begin
      link.rspLine <= txBusy_reg ? txSh_reg[cqm_pkg::RSP_W] : 1'b1;
      link.eventLine <= evtEn_reg[0] && urgency_reg != 8'h00;
      queueOn <= qEn_reg;
      queueSeq <= qSeq_reg;
    end
  end
endmodule : cqm_card

// file: cqm_pkg.sv
// Constants shared by both ends of the card maintenance and task queue link.
// Assumes a 100 MHz system clock on both ends and a host-made link clock.
package cqm_pkg;
  // Link frame: start bit, index, argument; answer: start bit, state, flags, data
  localparam int IDX_W   = 6;
  localparam int ARG_W   = 18;
  localparam int CMD_W   = IDX_W + ARG_W;
  localparam int RSP_W   = 14;
  localparam int ADDR_LSB = 8;
  localparam int ADDR_W  = 10;
  // Enhancement byte addresses
  localparam logic [9:0] EB_EVT_SUP   = 10'h001;
  localparam logic [9:0] EB_MAINT_SUP = 10'h002;
  localparam logic [9:0] EB_URGENCY   = 10'h003;
  localparam logic [9:0] EB_CACHE_SUP = 10'h004;
  localparam logic [9:0] EB_QUEUE     = 10'h006;
  localparam logic [9:0] EB_EVT_EN    = 10'h101;
  localparam logic [9:0] EB_MAINT_EN  = 10'h102;
  localparam logic [9:0] EB_POFF      = 10'h104;
  localparam logic [9:0] EB_CACHE_CTL = 10'h105;
  localparam logic [9:0] EB_QUEUE_CTL = 10'h106;
  // Field positions
  localparam int QC_EN_BIT   = 0;
  localparam int QC_SEQ_BIT  = 1;
  localparam int ME_CARD_BIT = 0;
  localparam int ME_SUST_BIT = 1;
  localparam int ME_HOST_BIT = 2;
  // Command indices and answer state codes
  localparam logic [5:0] C_RESET   = 6'h00;
  localparam logic [5:0] C_SWITCH  = 6'h06;
  localparam logic [5:0] C_STOP    = 6'h0C;
  localparam logic [5:0] C_STATUS  = 6'h0D;
  localparam logic [5:0] C_TUNE    = 6'h13;
  localparam logic [5:0] C_UADDR   = 6'h16;
  localparam logic [5:0] C_ESTART  = 6'h20;
  localparam logic [5:0] C_EEND    = 6'h21;
  localparam logic [5:0] C_ERASE   = 6'h26;
  localparam logic [5:0] C_QMGMT   = 6'h2B;
  localparam logic [5:0] C_TASKA   = 6'h2C;
  localparam logic [5:0] C_TASKB   = 6'h2D;
  localparam logic [5:0] C_EXRD    = 6'h2E;
  localparam logic [5:0] C_EXWR    = 6'h2F;
  localparam logic [5:0] C_XRD     = 6'h30;
  localparam logic [5:0] C_XWR     = 6'h31;
  localparam logic [5:0] C_XMRD    = 6'h3A;
  localparam logic [5:0] C_XMWR    = 6'h3B;
  localparam logic [3:0] ST_TRAN = 4'h4;
  localparam logic [3:0] ST_RDT  = 4'h5;
  localparam logic [3:0] ST_WDT  = 4'h6;
  localparam logic [3:0] ST_BSY  = 4'h7;
  // Timing
  localparam int  CLK_MHZ        = 100;
  localparam int  MAINT_LIMIT_MS = 1000;
  localparam longint MAINT_LIMIT_CYC = longint'(MAINT_LIMIT_MS) * 1000 * CLK_MHZ;
  localparam int  LINK_HALF_CYC  = 4;
  localparam int  RSP_TIMEOUT    = 64;
  // Host APB map
  localparam logic [7:0] A_CMD    = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_RESP   = 8'h08;
  typedef enum logic [1:0] {Q_TRAN, Q_RDT, Q_WDT, Q_BSY} cqm_qstate_t;
endpackage : cqm_pkg

// file: cqm_link_if.sv
// Link between host and card: clock, command line, answer line, event line.
// Assumes both ends share the system clock rate; the card treats all as async.
`timescale 1ns/1ps
interface cqm_link_if;
  logic linkClk;
  logic cmdLine;
  logic rspLine;
  logic eventLine;
  modport card (input linkClk, input cmdLine, output rspLine, output eventLine);
  modport host (output linkClk, output cmdLine, input rspLine, input eventLine);
endinterface : cqm_link_if

// file: cqm_host.sv
// Host end: APB slave holding a command register, link clock divider, answer capture.
// Assumes software keeps task order itself; the host only moves frames.
`timescale 1ns/1ps
module cqm_host (
  // System
  input  wire logic        clk,
  input  wire logic        rst,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Link
  cqm_link_if.host         link
);
  logic [2:0]  div_reg;
  logic        busy_reg, rxing_reg, tmo_reg, evt_reg;
  logic [6:0]  bitCnt_reg;
  logic [24:0] txSh_reg;
  logic [13:0] resp_reg;
  logic        rise, fall, wr;
  // Software should enable the cache before the queue; nothing here enforces it

  assign rise = div_reg == 3'(cqm_pkg::LINK_HALF_CYC - 1) && !link.linkClk;
  assign fall = div_reg == 3'(cqm_pkg::LINK_HALF_CYC - 1) && link.linkClk;
  assign wr   = psel && penable && pwrite && paddr == cqm_pkg::A_CMD && !busy_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= 3'h0;
      link.linkClk <= 1'b0;
    end else begin
      div_reg <= (div_reg == 3'(cqm_pkg::LINK_HALF_CYC - 1)) ? 3'h0 : div_reg + 3'h1;
      if (div_reg == 3'(cqm_pkg::LINK_HALF_CYC - 1)) link.linkClk <= !link.linkClk;
    end
  end

  // Send on falling edges, collect the answer on rising edges
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      rxing_reg <= 1'b0;
      tmo_reg <= 1'b0;
      bitCnt_reg <= 7'h00;
      txSh_reg <= '1;
      resp_reg <= 14'h0000;
      link.cmdLine <= 1'b1;
    end else if (wr) begin
      busy_reg <= 1'b1;
      tmo_reg <= 1'b0;
      bitCnt_reg <= 7'h00;
      txSh_reg <= {1'b0, pwdata[23:0]};
    end else if (busy_reg) begin
      if (fall && bitCnt_reg < 7'd25) begin
        link.cmdLine <= txSh_reg[24];
        txSh_reg <= {txSh_reg[23:0], 1'b1};
        bitCnt_reg <= bitCnt_reg + 7'h01;
      end else if (fall) begin
        link.cmdLine <= 1'b1;
      end
      // Counter must reach frame length plus the full answer wait
      if (rise && bitCnt_reg >= 7'd25) begin
        if (rxing_reg) begin
          resp_reg <= {resp_reg[12:0], link.rspLine};
          bitCnt_reg <= bitCnt_reg + 7'h01;
          if (bitCnt_reg == 7'd25 + 7'(cqm_pkg::RSP_W) - 7'h01) begin
            rxing_reg <= 1'b0;
            busy_reg <= 1'b0;
          end
        end else if (!link.rspLine) begin
          rxing_reg <= 1'b1;
          bitCnt_reg <= 7'd25;
        end else if (bitCnt_reg == 7'd25 + 7'(cqm_pkg::RSP_TIMEOUT)) begin
          tmo_reg <= 1'b1; // Illegal commands get no answer
          busy_reg <= 1'b0;
        end else begin
          bitCnt_reg <= bitCnt_reg + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      evt_reg <= 1'b0;
    end else begin
      evt_reg <= link.eventLine;
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr != cqm_pkg::A_CMD && paddr != cqm_pkg::A_STATUS
                 && paddr != cqm_pkg::A_RESP;
      case (paddr)
        cqm_pkg::A_STATUS: prdata <= {29'h0000_0000, evt_reg, tmo_reg, busy_reg};
        cqm_pkg::A_RESP:   prdata <= {18'h0_0000, resp_reg};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : cqm_host

// file: cqm_link_props.sv
// Link protocol checker for the card maintenance and task queue link.
// Assumes it sits beside the interface and shares the system clock and reset.
`timescale 1ns/1ps
module cqm_link_props (
  // System
  input wire logic clk,
  input wire logic rst,
  // Link
  input wire logic linkClk,
  input wire logic cmdLine,
  input wire logic rspLine,
  input wire logic eventLine
);
  logic [8:0] sinceCmd_reg;

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  // Starts saturated so an answer nobody asked for right after reset is caught
  always_ff @(posedge clk) begin
    if (rst) sinceCmd_reg <= 9'h1FF;
    else if (!cmdLine) sinceCmd_reg <= 9'h000;
    else if (sinceCmd_reg != 9'h1FF) sinceCmd_reg <= sinceCmd_reg + 9'h001;
  end

  link_reset_a: assert property (disable iff (1'b0) rst |=> !linkClk && cmdLine && rspLine && !eventLine)
    else $error("link not idle during reset");
  clk_high_a: assert property ($rose(linkClk) |-> linkClk [*4] ##1 !linkClk)
    else $error("link clock high phase wrong");
  clk_low_a: assert property ($fell(linkClk) |-> !linkClk [*4])
    else $error("link clock low phase short");
  cmd_steady_a: assert property (linkClk && $past(linkClk) |-> $stable(cmdLine))
    else $error("command line moved while link clock high");
  cmd_hold_a: assert property ($changed(cmdLine) |=> $stable(cmdLine) [*7])
    else $error("command bit shorter than a link period");
  rsp_hold_a: assert property ($changed(rspLine) |=> $stable(rspLine) [*7])
    else $error("answer bit shorter than a link period");
  rsp_quiet_a: assert property ($fell(cmdLine) |-> rspLine)
    else $error("card answering while a command is sent");
  rsp_solicited_a: assert property ($fell(rspLine) |-> sinceCmd_reg < 9'd256)
    else $error("answer without a preceding command");

  cover property ($fell(rspLine));
  cover property ($fell(cmdLine));
  cover property ($rose(eventLine));
endmodule : cqm_link_props

// file: tb.sv
// Self-checking bench: software view over APB on the host, card internals driven directly.
// Assumes the host makes the link clock and a shortened maintenance grant on the card.
`timescale 1ns/1ps
module tb;
  localparam longint MCYC = 400;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  maintUrgency;
  logic        maintWorkDone;
  logic        opDone;
  logic        maintActive;
  logic        queueOn;
  logic        queueSeq;
  logic        powerOffSafe;
  logic        errW;
  logic [31:0] rspW;
  logic [31:0] stW;
  int          failures;
  int          check_count;
  logic [9:0]  ebA [4] = '{cqm_pkg::EB_EVT_SUP, cqm_pkg::EB_MAINT_SUP, cqm_pkg::EB_URGENCY, cqm_pkg::EB_QUEUE};
  logic [7:0]  ebV [4] = '{8'h01, 8'h03, 8'h02, 8'h0F};
  logic [5:0]  legC [7] = '{cqm_pkg::C_SWITCH, cqm_pkg::C_STOP, cqm_pkg::C_ESTART, cqm_pkg::C_EEND,
                            cqm_pkg::C_TUNE, cqm_pkg::C_ERASE, cqm_pkg::C_XMWR};
  logic [3:0]  legS [7] = '{cqm_pkg::ST_TRAN, cqm_pkg::ST_TRAN, cqm_pkg::ST_TRAN, cqm_pkg::ST_TRAN,
                            cqm_pkg::ST_RDT, cqm_pkg::ST_BSY, cqm_pkg::ST_WDT};

  cqm_link_if cqm_link_if_i ();
  cqm_card #(.MAINT_CYCLES(MCYC), .QDEPTH(16)) cqm_card_i (
    .clk(clk), .rst(rst), .link(cqm_link_if_i), .maintUrgency(maintUrgency), .maintWorkDone(maintWorkDone),
    .opDone(opDone), .maintActive(maintActive), .queueOn(queueOn), .queueSeq(queueSeq),
    .powerOffSafe(powerOffSafe));
  cqm_host cqm_host_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(cqm_link_if_i));
  cqm_link_props cqm_link_props_i (
    .clk(clk), .rst(rst), .linkClk(cqm_link_if_i.linkClk), .cmdLine(cqm_link_if_i.cmdLine),
    .rspLine(cqm_link_if_i.rspLine), .eventLine(cqm_link_if_i.eventLine));

  always #5 clk = ~clk;

  task automatic complete_run();
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Released on the answer edge, then one idle edge so a following call never drives psel twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check(32'(pready), 32'h0000_0001, "apb answer");
    if (pready !== 1'b1) complete_run();
    q = prdata;
    errW = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic cmd(input logic [5:0] idx, input logic [17:0] arg);
    int n;
    n = 0;
    apb(1'b1, cqm_pkg::A_CMD, {8'h00, idx, arg}, rspW);
    do begin
      apb(1'b0, cqm_pkg::A_STATUS, 32'h0000_0000, stW);
      n++;
    end while (stW[0] !== 1'b0 && n < 1000);
    if (stW[0] !== 1'b0) begin
      failures++;
      complete_run();
    end
    apb(1'b0, cqm_pkg::A_RESP, 32'h0000_0000, rspW);
  endtask : cmd

  task automatic live(input logic [5:0] idx, input logic [17:0] arg);
    cmd(idx, arg);
    check(32'(stW[1]), 32'h0000_0000, "no answer");
  endtask : live

  task automatic refuse(input logic [5:0] idx, input logic [17:0] arg);
    cmd(idx, arg);
    check(32'(stW[1]), 32'h0000_0001, "refused command answered");
    live(cqm_pkg::C_STATUS, 18'h0_0000);
    check(32'(rspW[9]), 32'h0000_0001, "illegal flag");
  endtask : refuse

  task automatic rdb(input logic [9:0] a, input logic [7:0] exp);
    live(cqm_pkg::C_XRD, {a, 8'h00});
    check(32'(rspW[7:0]), 32'(exp), "byte read");
  endtask : rdb

  task automatic wrb(input logic [9:0] a, input logic [7:0] d);
    live(cqm_pkg::C_XWR, {a, d});
  endtask : wrb

  task automatic pulseOp();
    opDone <= 1'b1;
    @(posedge clk);
    opDone <= 1'b0;
    @(posedge clk);
  endtask : pulseOp

  // Selector 0 watches maintActive, 1 watches powerOffSafe
  task automatic settle(input int sel, input logic want, input string what);
    int n;
    n = 0;
    while ((sel == 0 ? maintActive : powerOffSafe) !== want && n < MCYC + 100) begin
      @(posedge clk);
      n++;
    end
    check(32'(sel == 0 ? maintActive : powerOffSafe), 32'(want), what);
  endtask : settle

  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; maintUrgency = 2'h2; maintWorkDone = 1'b0; opDone = 1'b0;
    failures = 0; check_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 8'h0C, 32'h0000_0000, rspW);
    check(32'(errW), 32'h0000_0001, "unmapped slverr");
    live(cqm_pkg::C_STATUS, 18'h0_0000);
    check(32'(rspW[13:0]), 32'h0000_107F, "status block");
    for (int i = 0; i < 4; i++) rdb(ebA[i], ebV[i]);
    for (int i = 0; i < 5; i++) refuse(cqm_pkg::C_QMGMT + 6'(i), 18'h0_0000);
    wrb(cqm_pkg::EB_CACHE_CTL, 8'h01);
    rdb(cqm_pkg::EB_CACHE_CTL, 8'h01);
    wrb(cqm_pkg::EB_QUEUE_CTL, 8'h01);
    check(32'({queueOn, queueSeq}), 32'h0000_0002, "voluntary mode");
    refuse(6'h11, 18'h0_0000);
    refuse(cqm_pkg::C_TASKA, 18'h0_0010);
    for (int i = 0; i < 7; i++) begin
      live(legC[i], 18'h0_0000);
      live(cqm_pkg::C_STATUS, 18'h0_0000);
      check(32'(rspW[13:10]), 32'(legS[i]), "queue state");
      pulseOp();
      live(cqm_pkg::C_STATUS, 18'h0_0000);
      check(32'(rspW[13:9]), 32'h0000_0008, "back to queue transfer state");
    end
    wrb(cqm_pkg::EB_QUEUE_CTL, 8'h00);
    wrb(cqm_pkg::EB_QUEUE_CTL, 8'h03);
    check(32'({queueOn, queueSeq}), 32'h0000_0003, "sequential mode");
    refuse(cqm_pkg::C_TASKA, 18'h0_0001);
    check(32'(rspW[8]), 32'h0000_0001, "sequence error flag");
    live(cqm_pkg::C_QMGMT, 18'h0_0000);
    pulseOp();
    live(cqm_pkg::C_TASKA, 18'h0_0000);
    live(cqm_pkg::C_TASKB, 18'h0_0000);
    live(cqm_pkg::C_EXWR, 18'h0_0000);
    live(cqm_pkg::C_STATUS, 18'h0_0000);
    check(32'(rspW[13:10]), 32'(cqm_pkg::ST_WDT), "write task state");
    check(32'(rspW[9:8]), 32'h0000_0000, "errors cleared by abort");
    pulseOp();
    wrb(cqm_pkg::EB_QUEUE_CTL, 8'h00);
    check(32'({queueOn, queueSeq}), 32'h0000_0000, "queue off");
    wrb(cqm_pkg::EB_EVT_EN, 8'h01);
    apb(1'b0, cqm_pkg::A_STATUS, 32'h0000_0000, stW);
    check(32'(stW[2]), 32'h0000_0001, "event raised");
    wrb(cqm_pkg::EB_MAINT_EN, 8'h04);
    check(32'(maintActive), 32'h0000_0001, "host run started");
    settle(0, 1'b0, "grant expiry");
    rdb(cqm_pkg::EB_URGENCY, 8'h02);
    wrb(cqm_pkg::EB_MAINT_EN, 8'h00);
    wrb(cqm_pkg::EB_MAINT_EN, 8'h04);
    check(32'(maintActive), 32'h0000_0001, "second run started");
    maintWorkDone <= 1'b1;
    maintUrgency  <= 2'h0;
    @(posedge clk);
    maintWorkDone <= 1'b0;
    settle(0, 1'b0, "run ends on work done");
    rdb(cqm_pkg::EB_URGENCY, 8'h00);
    apb(1'b0, cqm_pkg::A_STATUS, 32'h0000_0000, stW);
    check(32'(stW[2]), 32'h0000_0000, "event dropped");
    maintUrgency <= 2'h1;
    wrb(cqm_pkg::EB_MAINT_EN, 8'h03);
    settle(0, 1'b1, "card run on idle bus");
    wrb(cqm_pkg::EB_POFF, 8'h01);
    settle(1, 1'b1, "power off safe");
    settle(0, 1'b0, "run stopped by notice");
    complete_run();
  end
endmodule : tb
